// file: pkg/sdw_consts.svh
`ifndef SDW_CONSTS_SVH
`define SDW_CONSTS_SVH
// frame layout
`define SDW_FRAME_BITS 16
`define SDW_BYTE_BITS 8
`define SDW_MODE_HI 15
`define SDW_MODE_LO 14
`define SDW_DATA_TOP 13
`define SDW_DAC_RES 12
// timing
`define SDW_CLK_MHZ 125
`define SDW_SCLK_MAX_MHZ 30
`define SDW_SCLK_HALF_CYC \
    ((`SDW_CLK_MHZ + 2 * `SDW_SCLK_MAX_MHZ - 1) / (2 * `SDW_SCLK_MAX_MHZ))
`define SDW_SYNC_HI_NS 33
`define SDW_SYNC_HI_CYC ((`SDW_SYNC_HI_NS * `SDW_CLK_MHZ + 999) / 1000)
`define SDW_WAKE_5V_US 13
`define SDW_WAKE_3V_US 16
`define SDW_WAKE_5V_CYC (`SDW_WAKE_5V_US * `SDW_CLK_MHZ)
`define SDW_WAKE_3V_CYC (`SDW_WAKE_3V_US * `SDW_CLK_MHZ)
`endif

// file: pkg/sdw_pkg.sv
package sdw_pkg;
    // operating modes in frame-code order 00,01,10,11
    typedef enum logic [1:0] {
        SDW_NORMAL,
        SDW_PD_1K,
        SDW_PD_100K,
        SDW_PD_HIZ
    } sdw_mode_t;
    // host sequencer states
    typedef enum logic [2:0] {
        SDW_H_IDLE,
        SDW_H_GAP,
        SDW_H_LEAD,
        SDW_H_HIGH,
        SDW_H_LOW,
        SDW_H_BYTE,
        SDW_H_END
    } sdw_hstate_t;
endpackage

// file: pkg/sdw_link_if.sv
`timescale 1ns/1ps
// three-wire write link, host drives every wire
interface sdw_link_if;
    logic sync_n; // frame select, active low
    logic sclk;   // serial clock
    logic serial_data_in; // serial data, msb first
    modport host (output sync_n, output sclk, output serial_data_in);
    modport dev (input sync_n, input sclk, input serial_data_in);
endinterface

// file: hw/sdw_dev.sv
// Notes on behaviour
// R1: frame starts on select falling edge
// R2: sample data on falling clock edges
// R3: sixteenth edge captures bit, applies frame
// R4: host keeps select high 33 ns
// R5: host may park select low
// R6: first two bits are mode field
// R7: 12-bit code follows mode, last two ignored
// R8: shorter codes follow mode, msb first
// R9: early select rise discards frame
// R10: power-up loads zero code
// R11: mode 00 normal, 01 1k, 10 100k, 11 open
// R12: power-down switches output, stops amplifier
// R13: power-down keeps dac code
// R14: wake takes 13 us or 16 us
// R15: code is straight binary
// R16: clock up to 30 MHz
// R17: host sends msb first
// R18: byte hosts keep select low across bytes
// R19: host uses cpol 0, cpha 1
// R20: extra edges ignored until next frame
`timescale 1ns/1ps
`include "sdw_consts.svh"
module sdw_dev #(
    parameter int RES = `SDW_DAC_RES // 12, 10 or 8 bit variant
) (
    input wire logic clk_i, // core clock
    input wire logic rst_n_i, // power-on reset, active low
    sdw_link_if.dev link, // serial write link
    input wire logic supply_5v_i, // high at 5 V supply, pin
    output logic [`SDW_DAC_RES-1:0] dac_code_o, // dac register
    output logic [1:0] mode_o, // operating mode
    output logic amp_en_o, // bias, amp and string on
    output logic term_1k_o, // output to ground via 1k
    output logic term_100k_o, // output to ground via 100k
    output logic out_hiz_o, // output open
    output logic out_valid_o, // output settled
    output logic update_o // frame applied pulse
);
    localparam logic [4:0] LAST_BIT = 5'(`SDW_FRAME_BITS - 1);
    localparam logic [4:0] DONE_CNT = 5'(`SDW_FRAME_BITS);
    localparam logic [10:0] WAKE_5V = 11'(`SDW_WAKE_5V_CYC);
    localparam logic [10:0] WAKE_3V = 11'(`SDW_WAKE_3V_CYC);

    // ---- link domain, clocked by the serial clock ----
    logic [`SDW_FRAME_BITS-1:0] shift_r;
    logic [`SDW_FRAME_BITS-1:0] shift_nxt;
    logic [4:0] bit_cnt_r;
    logic [`SDW_FRAME_BITS-1:0] word_r;
    logic commit_tgl_r;
    logic link_clr;
    logic bit_take;

    // select high or power-on holds the shifter clear
    assign link_clr = link.sync_n | ~rst_n_i; // R1 R9
    // shifting stops after the sixteenth edge
    assign bit_take = (bit_cnt_r != DONE_CNT); // R20
    // msb arrives first, so shift towards the top
    assign shift_nxt = {shift_r[`SDW_FRAME_BITS-2:0],
        link.serial_data_in}; // R2

    // shift register and edge count, armed by select low
    always_ff @(negedge link.sclk or posedge link_clr) begin // R16
        if (link_clr) begin
            shift_r <= '0; // R9
            bit_cnt_r <= '0; // R1
        end else if (bit_take) begin
            shift_r <= shift_nxt; // R2
            bit_cnt_r <= bit_cnt_r + 5'h01;
        end
    end

    // whole frame held and flagged by a toggle
    always_ff @(negedge link.sclk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            word_r <= '0;
            commit_tgl_r <= 1'b0;
        end else if (bit_cnt_r == LAST_BIT) begin
            word_r <= shift_nxt; // R3
            commit_tgl_r <= ~commit_tgl_r; // R3
        end
    end

    // ---- core domain ----
    logic tgl_s1_r;
    logic tgl_s2_r;
    logic tgl_seen_r;
    logic sup_s1_r;
    logic sup_s2_r;
    logic commit;
    logic [1:0] mode_r;
    logic [`SDW_DAC_RES-1:0] code_r;
    logic [10:0] wake_r;
    logic [10:0] wake_nxt;
    logic upd_r;
    logic [1:0] new_mode;
    logic [`SDW_DAC_RES-1:0] new_code;
    logic new_normal;
    logic powered_down;
    logic amp_en_nxt;
    logic term_1k_nxt;
    logic term_100k_nxt;
    logic out_hiz_nxt;
    logic out_valid_nxt;
    logic amp_en_r;
    logic term_1k_r;
    logic term_100k_r;
    logic out_hiz_r;
    logic out_valid_r;

    // toggle crossing; word_r is stable for many edges
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tgl_s1_r <= 1'b0;
            tgl_s2_r <= 1'b0;
            tgl_seen_r <= 1'b0;
        end else begin
            tgl_s1_r <= commit_tgl_r;
            tgl_s2_r <= tgl_s1_r;
            tgl_seen_r <= tgl_s2_r;
        end
    end

    // supply level pin, two flops
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sup_s1_r <= 1'b0;
            sup_s2_r <= 1'b0;
        end else begin
            sup_s1_r <= supply_5v_i;
            sup_s2_r <= sup_s1_r;
        end
    end

    // frame decode: mode field then msb-aligned code
    assign commit = tgl_s2_r ^ tgl_seen_r;
    assign new_mode = word_r[`SDW_MODE_HI:`SDW_MODE_LO]; // R6 R11
    assign new_code = `SDW_DAC_RES'(
        word_r[`SDW_DATA_TOP -: RES]); // R7 R8 R15
    assign new_normal = (new_mode == 2'(sdw_pkg::SDW_NORMAL));
    assign powered_down = (mode_r != 2'(sdw_pkg::SDW_NORMAL));

    // wake timer loads when power-down is left
    always_comb begin
        wake_nxt = wake_r;
        if (commit && new_normal && powered_down) begin
            wake_nxt = sup_s2_r ? WAKE_5V : WAKE_3V; // R14
        end else if (wake_r != 11'h000) begin
            wake_nxt = wake_r - 11'h001;
        end
    end

    // mode and dac registers, zero after power-up
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mode_r <= 2'h0;
            code_r <= '0; // R10
        end else if (commit) begin
            mode_r <= new_mode; // R3 R11
            if (new_normal) begin
                code_r <= new_code; // R3 R13
            end
        end
    end

    // wake count and update pulse
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wake_r <= 11'h000;
            upd_r <= 1'b0;
        end else begin
            wake_r <= wake_nxt;
            upd_r <= commit;
        end
    end

    // output stage decode from the mode register
    assign amp_en_nxt = ~powered_down; // R12
    assign term_1k_nxt = (mode_r == 2'(sdw_pkg::SDW_PD_1K)); // R12
    assign term_100k_nxt = (mode_r == 2'(sdw_pkg::SDW_PD_100K)); // R12
    assign out_hiz_nxt = (mode_r == 2'(sdw_pkg::SDW_PD_HIZ)); // R12
    assign out_valid_nxt = ~powered_down & (wake_r == 11'h000); // R14

    // output stage flops, one cycle behind the mode register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            amp_en_r <= 1'b1;
            term_1k_r <= 1'b0;
            term_100k_r <= 1'b0;
            out_hiz_r <= 1'b0;
            out_valid_r <= 1'b1; // R10
        end else begin
            amp_en_r <= amp_en_nxt;
            term_1k_r <= term_1k_nxt;
            term_100k_r <= term_100k_nxt;
            out_hiz_r <= out_hiz_nxt;
            out_valid_r <= out_valid_nxt;
        end
    end

    // outputs straight from flops
    assign dac_code_o = code_r; // R15
    assign mode_o = mode_r;
    assign amp_en_o = amp_en_r;
    assign term_1k_o = term_1k_r;
    assign term_100k_o = term_100k_r;
    assign out_hiz_o = out_hiz_r;
    assign out_valid_o = out_valid_r;
    assign update_o = upd_r;
endmodule // sdw_dev

// file: hw/sdw_host.sv
`timescale 1ns/1ps
`include "sdw_consts.svh"
module sdw_host (
    input wire logic clk_i, // core clock
    input wire logic rst_n_i, // reset, active low
    sdw_link_if.host link, // serial write link
    input wire logic req_valid_i, // frame request
    output logic req_ready_o, // request taken when high
    input wire logic [1:0] mode_i, // mode field
    input wire logic [13:0] data_i, // code, msb aligned
    input wire logic byte_mode_i, // send as two bytes
    input wire logic park_low_i, // leave select low after
    output logic done_o // frame sent pulse
);
    localparam logic [3:0] HALF = 4'(`SDW_SCLK_HALF_CYC - 1);
    localparam logic [3:0] GAP = 4'(`SDW_SYNC_HI_CYC - 1);
    localparam logic [4:0] ALL_BITS = 5'(`SDW_FRAME_BITS);
    localparam logic [4:0] BYTE_BITS = 5'(`SDW_BYTE_BITS);

    sdw_pkg::sdw_hstate_t state_r, state_nxt;
    logic [3:0] tmr_r, tmr_nxt;
    logic [4:0] bit_r, bit_nxt;
    logic [15:0] word_r, word_nxt;
    logic sync_n_r, sync_n_nxt;
    logic sclk_r, sclk_nxt;
    logic sdo_r, sdo_nxt;
    logic byte_r, byte_nxt;
    logic park_r, park_nxt;
    logic done_r, done_nxt;
    logic tmr_zero;
    logic frame_end;
    logic byte_pause;

    assign tmr_zero = (tmr_r == 4'h0);
    assign frame_end = (bit_r == ALL_BITS);
    assign byte_pause = byte_r & (bit_r == BYTE_BITS); // R18
    assign req_ready_o = (state_r == sdw_pkg::SDW_H_IDLE);

    // sequencer: rising edge drives a bit, falling edge samples
    always_comb begin
        state_nxt = state_r;
        tmr_nxt = tmr_zero ? tmr_r : tmr_r - 4'h1;
        bit_nxt = bit_r;
        word_nxt = word_r;
        sync_n_nxt = sync_n_r;
        sclk_nxt = sclk_r;
        sdo_nxt = sdo_r;
        byte_nxt = byte_r;
        park_nxt = park_r;
        done_nxt = 1'b0;
        unique case (state_r)
            sdw_pkg::SDW_H_IDLE: begin
                if (req_valid_i) begin
                    word_nxt = {mode_i, data_i}; // R17
                    byte_nxt = byte_mode_i;
                    park_nxt = park_low_i;
                    bit_nxt = 5'h00;
                    sync_n_nxt = 1'b1; // R4 R5
                    tmr_nxt = GAP;
                    state_nxt = sdw_pkg::SDW_H_GAP;
                end
            end
            sdw_pkg::SDW_H_GAP: begin
                if (tmr_zero) begin
                    sync_n_nxt = 1'b0; // R1
                    tmr_nxt = HALF;
                    state_nxt = sdw_pkg::SDW_H_LEAD;
                end
            end
            sdw_pkg::SDW_H_HIGH: begin
                if (tmr_zero) begin
                    sclk_nxt = 1'b0; // R19
                    tmr_nxt = HALF; // R16
                    state_nxt = sdw_pkg::SDW_H_LOW;
                end
            end
            sdw_pkg::SDW_H_END: begin
                sync_n_nxt = ~park_r; // R5
                done_nxt = 1'b1;
                state_nxt = sdw_pkg::SDW_H_IDLE;
            end
            default: begin
                // lead and byte pause end in a rising edge; low does too unless the frame or first byte is done
                if (tmr_zero) begin
                    if (state_r == sdw_pkg::SDW_H_LOW && frame_end) begin
                        state_nxt = sdw_pkg::SDW_H_END;
                    end else if (state_r == sdw_pkg::SDW_H_LOW &&
                                 byte_pause) begin
                        tmr_nxt = GAP; // R18
                        state_nxt = sdw_pkg::SDW_H_BYTE;
                    end else begin
                        sclk_nxt = 1'b1; // R19
                        sdo_nxt = word_r[15]; // R17
                        word_nxt = {word_r[14:0], 1'b0};
                        bit_nxt = bit_r + 5'h01;
                        tmr_nxt = HALF; // R16
                        state_nxt = sdw_pkg::SDW_H_HIGH;
                    end
                end
            end
        endcase
    end

    // sequencer state
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_r <= sdw_pkg::SDW_H_IDLE;
            tmr_r <= 4'h0;
            bit_r <= 5'h00;
            word_r <= 16'h0000;
            byte_r <= 1'b0;
            park_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            tmr_r <= tmr_nxt;
            bit_r <= bit_nxt;
            word_r <= word_nxt;
            byte_r <= byte_nxt;
            park_r <= park_nxt;
        end
    end

    // link pins and done pulse, all registered
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sync_n_r <= 1'b1;
            sclk_r <= 1'b0;
            sdo_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            sync_n_r <= sync_n_nxt;
            sclk_r <= sclk_nxt;
            sdo_r <= sdo_nxt;
            done_r <= done_nxt;
        end
    end

    assign link.sync_n = sync_n_r;
    assign link.sclk = sclk_r;
    assign link.serial_data_in = sdo_r;
    assign done_o = done_r;
endmodule // sdw_host

// file: bench/sdw_link_monitor.sv
`timescale 1ns/1ps
module sdw_link_monitor (
    input wire logic clk_i, // core clock
    input wire logic rst_n_i, // reset, active low
    input wire logic sync_n_i, // frame select, active low
    input wire logic sclk_i, // serial clock
    input wire logic serial_data_in_i // serial data
);
    logic [4:0] fall_cnt_r;

    // serial clock falls seen inside the current frame
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || sync_n_i) begin
            fall_cnt_r <= 5'h0;
        end else if ($fell(sclk_i)) begin
            fall_cnt_r <= fall_cnt_r + 5'h1;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // link timing and framing as driven by the host end
    sync_gap_a: assert property ($rose(sync_n_i) |-> sync_n_i [*5])
        else $error("select high gap too short");
    clk_high_a: assert property ($rose(sclk_i) |-> sclk_i [*3])
        else $error("serial clock high phase too short");
    clk_low_a: assert property ($fell(sclk_i) |-> !sclk_i [*3])
        else $error("serial clock low phase too short");
    data_hold_a: assert property (
        $fell(sclk_i) |-> $stable(serial_data_in_i))
        else $error("data moved at falling clock edge");
    clk_idle_a: assert property (sync_n_i |-> !sclk_i)
        else $error("serial clock not idle low outside frame");
    frame_lead_a: assert property ($fell(sync_n_i) |-> !sclk_i [*3])
        else $error("clock edge too soon after select fall");
    fall_inside_a: assert property ($fell(sclk_i) |-> !sync_n_i)
        else $error("falling clock edge outside frame");
    frame_len_a: assert property (
        $rose(sync_n_i) |-> fall_cnt_r == 5'h10)
        else $error("frame closed without sixteen edges");
endmodule // sdw_link_monitor

// file: bench/sdw_tb_top.sv
`timescale 1ns/1ps
module sdw_tb_top;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b1; // falls at the first falling edge
    logic req_valid_i = 1'b0;
    logic [1:0] mode_i = 2'h0;
    logic [13:0] data_i = 14'h0;
    logic byte_mode_i = 1'b0;
    logic park_low_i = 1'b0;
    logic supply_5v_i = 1'b1;
    logic req_ready_o, done_o, amp_en_o, term_1k_o, term_100k_o;
    logic out_hiz_o, out_valid_o, update_o, update2;
    logic [11:0] dac_code_o, code2;
    logic [1:0] mode_o, mode2;
    logic [3:0] out_stage;
    int miscompares = 0;
    int tests_run = 0;
    int upd2_cnt = 0;
    int upd_cnt = 0;

    sdw_link_if link();
    sdw_link_if link2();

    // host and device joined, plus a second device driven by hand
    sdw_host u_sdw_host (.clk_i, .rst_n_i, .link(link.host), .req_valid_i,
        .req_ready_o, .mode_i, .data_i, .byte_mode_i, .park_low_i, .done_o);
    sdw_dev u_sdw_dev (.clk_i, .rst_n_i, .link(link.dev), .supply_5v_i,
        .dac_code_o, .mode_o, .amp_en_o, .term_1k_o, .term_100k_o,
        .out_hiz_o, .out_valid_o, .update_o);
    sdw_dev #(.RES(10)) u_sdw_dev_b (.clk_i, .rst_n_i, .link(link2.dev),
        .supply_5v_i, .dac_code_o(code2), .mode_o(mode2), .amp_en_o(),
        .term_1k_o(), .term_100k_o(), .out_hiz_o(), .out_valid_o(),
        .update_o(update2));
    sdw_link_monitor u_sdw_link_monitor (.clk_i, .rst_n_i,
        .sync_n_i(link.sync_n), .sclk_i(link.sclk),
        .serial_data_in_i(link.serial_data_in));

    // clock, output stage view, update counters of both devices
    assign out_stage = {amp_en_o, term_1k_o, term_100k_o, out_hiz_o};
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) if (update2) upd2_cnt <= upd2_cnt + 1;
    always @(posedge clk_i) if (update_o) upd_cnt <= upd_cnt + 1;

    task chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task wrap_up;
        if (miscompares == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task send(input logic [1:0] m, input logic [13:0] d, input logic bm,
              input logic pk);
        int n;
        int u;
        n = 0;
        u = upd_cnt;
        @(negedge clk_i);
        mode_i = m;
        data_i = d;
        byte_mode_i = bm;
        park_low_i = pk;
        req_valid_i = 1'b1;
        while (req_ready_o !== 1'b1 && n < 300) begin
            @(negedge clk_i);
            n++;
        end
        @(negedge clk_i);
        req_valid_i = 1'b0;
        chk(16'(req_ready_o), 16'h0000);
        n = 0;
        while (done_o !== 1'b1 && n < 300) begin
            @(negedge clk_i);
            n++;
        end
        chk(16'(done_o), 16'h0001);
        repeat (10) @(negedge clk_i);
        chk(16'(upd_cnt - u), 16'h0001);
    endtask

    // hand-made link frames at a 125 ns serial clock
    task lbit(input logic b);
        link2.sclk = 1'b1;
        link2.serial_data_in = b;
        #62.5 link2.sclk = 1'b0;
        #62.5;
    endtask

    task lframe(input logic [19:0] w, input int nb);
        link2.sync_n = 1'b0;
        #50;
        for (int i = 19; i > 19 - nb; i--) lbit(w[i]);
        link2.sync_n = 1'b1;
        link2.serial_data_in = ~link2.serial_data_in;
        #100;
        repeat (10) @(negedge clk_i);
    endtask

    task t_reset;
        chk(16'(dac_code_o), 16'h0000);
        chk(16'(mode_o), 16'h0000);
        chk(16'(out_stage), 16'h0008);
        chk(16'(out_valid_o), 16'h0001);
    endtask

    task t_normal;
        logic [13:0] dv [4];
        dv = '{14'h2A5B, 14'h0003, 14'h3FFF, 14'h1573};
        for (int i = 0; i < 4; i++) begin
            send(2'h0, dv[i], i[0], i[1]);
            chk(16'(dac_code_o), 16'(dv[i][13:2]));
            chk(16'(mode_o), 16'h0000);
        end
    endtask

    task t_modes;
        for (int m = 1; m < 4; m++) begin
            send(2'(m), 14'h0F0F, 1'b0, 1'b0);
            chk(16'(mode_o), 16'(m));
            chk(16'(dac_code_o), 16'h055C);
            chk(16'(out_stage), 16'(4'h8 >> m));
            chk(16'(out_valid_o), 16'h0000);
        end
    endtask

    task t_wake;
        send(2'h0, 14'h1234, 1'b0, 1'b0);
        chk(16'(dac_code_o), 16'h048D);
        chk(16'(out_valid_o), 16'h0000);
        repeat (1600) @(negedge clk_i);
        chk(16'(out_valid_o), 16'h0000);
        repeat (40) @(negedge clk_i);
        chk(16'(out_valid_o), 16'h0001);
        chk(16'(out_stage), 16'h0008);
        // same wake-up at the lower supply figure
        supply_5v_i = 1'b0;
        send(2'h1, 14'h0000, 1'b0, 1'b0);
        chk(16'(dac_code_o), 16'h048D);
        chk(16'(out_valid_o), 16'h0000);
        send(2'h0, 14'h1234, 1'b0, 1'b0);
        repeat (1980) @(negedge clk_i);
        chk(16'(out_valid_o), 16'h0000);
        repeat (20) @(negedge clk_i);
        chk(16'(out_valid_o), 16'h0001);
        chk(16'(dac_code_o), 16'h048D);
    endtask

    task t_abort;
        lframe(20'hFFFC0, 10);
        chk(16'(mode2), 16'h0000);
        chk(16'(upd2_cnt), 16'h0000);
        lframe(20'h2AA8F, 20);
        chk(16'(code2[9:0]), 16'h02AA);
        chk(16'(upd2_cnt), 16'h0001);
        lframe(20'hC0000, 15);
        chk(16'(mode2), 16'h0000);
        chk(16'(code2[9:0]), 16'h02AA);
    endtask

    // watchdog against a hung handshake
    initial begin
        #200000;
        miscompares++;
        wrap_up();
    end

    // main sequence
    initial begin
        // reset falls as a real edge so the link-side clears fire
        @(negedge clk_i);
        rst_n_i = 1'b0;
        link2.sync_n = 1'b1;
        link2.sclk = 1'b0;
        link2.serial_data_in = 1'b0;
        repeat (10) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (2) @(negedge clk_i);
        t_reset();
        t_normal();
        t_modes();
        t_wake();
        t_abort();
        wrap_up();
    end
endmodule // sdw_tb_top
